// ===== hw/lpcb_group_counter.sv
// per-group pulse counter and current level
`timescale 1ns/1ps
`default_nettype none
module lpcb_group_counter (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// control from the sequencer
	input wire logic count_en,
	input wire logic clear,
	// synchronised enable level and its rising edge
	input wire logic en_level,
	input wire logic en_rise,
	input wire logic drive_on,
	// level in fifteenths of full-scale current
	output logic [lpcb_pkg::STEP_W-1:0] level,
	output logic group_on
);
	logic [lpcb_pkg::STEP_W-1:0] step_ff;
	logic seen_ff;
	logic [lpcb_pkg::STEP_W-1:0] level_ff;
	logic on_ff;
	// first edge lands on step 1; later edges advance, wrapping 16 to 1
	always_ff @(posedge clock) begin
		if (!rstn) begin
			step_ff <= lpcb_pkg::STEP_FULL;
			seen_ff <= 1'b0;
		end else if (clear) begin
			step_ff <= lpcb_pkg::STEP_FULL;
			seen_ff <= 1'b0;
		end else if (count_en && en_rise) begin
			seen_ff <= 1'b1;
			if (!seen_ff) begin
				step_ff <= lpcb_pkg::STEP_FULL;
			end else begin
				step_ff <= step_ff + 4'h1;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (!rstn) begin
			level_ff <= 4'h0;
			on_ff <= 1'b0;
		end else begin
			// off in soft-start, while enable is low, and at step 16
			on_ff <= drive_on && en_level && (step_ff != lpcb_pkg::STEP_OFF);
			level_ff <= (drive_on && en_level) ? lpcb_pkg::LEVEL_MAX - step_ff : 4'h0;
		end
	end
	assign level = level_ff;
	assign group_on = on_ff;
endmodule // lpcb_group_counter
`default_nettype wire

// ===== hw/lpcb_pkg.sv
// constants and types shared by the led pulse-count brightness block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package lpcb_pkg;
	localparam int CLOCK_HZ = 25000000;
	localparam int STEP_W = 4;
	localparam int NUM_CH = 6;
	localparam logic [STEP_W-1:0] STEP_FULL = 4'h0; // code 0 is step 1
	localparam logic [STEP_W-1:0] STEP_OFF = 4'hF; // code 15 is step 16
	localparam logic [STEP_W-1:0] LEVEL_MAX = 4'hF; // fifteen fifteenths
	// times in nanoseconds, as printed
	localparam int POWER_ON_RESET_TIME_NS = 50000;
	localparam int SOFT_START_TIME_NS = 1300000;
	localparam int ENABLE_LOW_HOLD_MIN_NS = 1170000;
	localparam int ENABLE_LOW_HOLD_TYP_NS = 1370000;
	localparam int POR_CYCLES = (POWER_ON_RESET_TIME_NS / 1000) * (CLOCK_HZ / 1000000);
	localparam int SOFT_START_CYCLES = (SOFT_START_TIME_NS / 1000) * (CLOCK_HZ / 1000000);
	localparam int HOLD_CYCLES = (ENABLE_LOW_HOLD_TYP_NS / 1000) * (CLOCK_HZ / 1000000);
	localparam int TIMER_W = 20;
	typedef enum logic [1:0] {
		LPCB_ST_POR,
		LPCB_ST_STANDBY,
		LPCB_ST_SOFT,
		LPCB_ST_RUN
	} lpcb_state_t;
endpackage

// ===== hw/lpcb_sync.sv
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module lpcb_sync (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// pin and synchronised level
	input wire logic pin_in,
	output logic sync_out
);
	logic meta_ff;
	logic sync_ff;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end
	assign sync_out = sync_ff;
endmodule // lpcb_sync
`default_nettype wire

// ===== hw/lpcb_top.sv
// led pulse-count brightness sequencer and channel mapping
`timescale 1ns/1ps
`default_nettype none
module lpcb_top #(
	parameter int POR_CYCLES = lpcb_pkg::POR_CYCLES,
	parameter int SOFT_START_CYCLES = lpcb_pkg::SOFT_START_CYCLES,
	parameter int HOLD_CYCLES = lpcb_pkg::HOLD_CYCLES
) (
	// clock and reset (rstn models supply application)
	input wire logic clock,
	input wire logic rstn,
	// enable pulse lines from the host
	input wire logic group_a_enable_in,
	input wire logic group_b_enable_in,
	// channel split straps
	input wire logic group_split_sel_hi,
	input wire logic group_split_sel_lo,
	// per-channel current level, fifteenths of full scale, and drive enable
	output logic [lpcb_pkg::STEP_W-1:0] led_sink_level [lpcb_pkg::NUM_CH],
	output logic [lpcb_pkg::NUM_CH-1:0] led_sink_on,
	// status
	output logic chip_enable,
	output logic startup_active
);
	// ------------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------------
	logic a_s;
	logic b_s;
	logic sel_hi_s;
	logic sel_lo_s;
	lpcb_sync u_sync_a (.clock(clock), .rstn(rstn), .pin_in(group_a_enable_in), .sync_out(a_s));
	lpcb_sync u_sync_b (.clock(clock), .rstn(rstn), .pin_in(group_b_enable_in), .sync_out(b_s));
	lpcb_sync u_sync_h (.clock(clock), .rstn(rstn), .pin_in(group_split_sel_hi),
		.sync_out(sel_hi_s));
	lpcb_sync u_sync_l (.clock(clock), .rstn(rstn), .pin_in(group_split_sel_lo),
		.sync_out(sel_lo_s));

	logic a_d_ff;
	logic b_d_ff;
	logic a_rise;
	logic b_rise;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			a_d_ff <= 1'b0;
			b_d_ff <= 1'b0;
		end else begin
			a_d_ff <= a_s;
			b_d_ff <= b_s;
		end
	end
	assign a_rise = a_s && !a_d_ff;
	assign b_rise = b_s && !b_d_ff;

	// ------------------------------------------------------------------------
	// sequencer: power-on reset, standby, soft-start, run
	// ------------------------------------------------------------------------
	lpcb_pkg::lpcb_state_t state_ff;
	lpcb_pkg::lpcb_state_t nxt_state;
	logic [lpcb_pkg::TIMER_W-1:0] timer_ff;
	logic [lpcb_pkg::TIMER_W-1:0] low_ff;
	logic timer_done;
	logic hold_done;
	logic any_rise;
	logic clear_cnt;

	assign any_rise = a_rise || b_rise;
	assign timer_done = (timer_ff == lpcb_pkg::TIMER_W'(1));
	assign hold_done = (low_ff >= lpcb_pkg::TIMER_W'(HOLD_CYCLES));

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			lpcb_pkg::LPCB_ST_POR: begin
				// enables already high at power-up start after the reset time
				if (timer_done) begin
					nxt_state = (a_s || b_s) ? lpcb_pkg::LPCB_ST_SOFT : lpcb_pkg::LPCB_ST_STANDBY;
				end
			end
			lpcb_pkg::LPCB_ST_STANDBY: begin
				if (any_rise) begin
					nxt_state = lpcb_pkg::LPCB_ST_SOFT;
				end
			end
			lpcb_pkg::LPCB_ST_SOFT: begin
				if (hold_done) begin
					nxt_state = lpcb_pkg::LPCB_ST_STANDBY;
				end else if (timer_done) begin
					nxt_state = lpcb_pkg::LPCB_ST_RUN;
				end
			end
			lpcb_pkg::LPCB_ST_RUN: begin
				if (hold_done) begin
					nxt_state = lpcb_pkg::LPCB_ST_STANDBY;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_ff <= lpcb_pkg::LPCB_ST_POR;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// one down-counter serves both the reset gate and the soft-start wait
	always_ff @(posedge clock) begin
		if (!rstn) begin
			timer_ff <= lpcb_pkg::TIMER_W'(POR_CYCLES);
		end else if (state_ff != lpcb_pkg::LPCB_ST_SOFT && nxt_state == lpcb_pkg::LPCB_ST_SOFT) begin
			timer_ff <= lpcb_pkg::TIMER_W'(SOFT_START_CYCLES);
		end else if (timer_ff != lpcb_pkg::TIMER_W'(0)) begin
			timer_ff <= timer_ff - lpcb_pkg::TIMER_W'(1);
		end
	end

	// both-low hold timer; any high level restarts it
	always_ff @(posedge clock) begin
		if (!rstn) begin
			low_ff <= '0;
		end else if (a_s || b_s || state_ff == lpcb_pkg::LPCB_ST_STANDBY
				|| state_ff == lpcb_pkg::LPCB_ST_POR) begin
			low_ff <= '0;
		end else if (!hold_done) begin
			low_ff <= low_ff + lpcb_pkg::TIMER_W'(1);
		end
	end

	// counters are held clear in power-on reset and cleared in the cycle that enters standby, so entry to power-save clears them
	assign clear_cnt = (state_ff == lpcb_pkg::LPCB_ST_POR) || (nxt_state == lpcb_pkg::LPCB_ST_STANDBY
		&& state_ff != lpcb_pkg::LPCB_ST_STANDBY);

	logic count_en;
	logic drive_on;
	// the waking edge in standby is itself counted as the first pulse
	assign count_en = (state_ff != lpcb_pkg::LPCB_ST_POR);
	assign drive_on = (state_ff == lpcb_pkg::LPCB_ST_RUN);

	// ------------------------------------------------------------------------
	// per-group counters
	// ------------------------------------------------------------------------
	logic [lpcb_pkg::STEP_W-1:0] lvl_a;
	logic [lpcb_pkg::STEP_W-1:0] lvl_b;
	logic on_a;
	logic on_b;
	lpcb_group_counter u_grp_a (
		.clock(clock), .rstn(rstn), .count_en(count_en), .clear(clear_cnt),
		.en_level(a_s), .en_rise(a_rise), .drive_on(drive_on), .level(lvl_a), .group_on(on_a)
	);
	lpcb_group_counter u_grp_b (
		.clock(clock), .rstn(rstn), .count_en(count_en), .clear(clear_cnt),
		.en_level(b_s), .en_rise(b_rise), .drive_on(drive_on), .level(lvl_b), .group_on(on_b)
	);

	// ------------------------------------------------------------------------
	// channel split: group b takes the top channels
	// ------------------------------------------------------------------------
	logic [2:0] b_count;
	always_comb begin
		unique case ({sel_hi_s, sel_lo_s})
			2'b00: b_count = 3'h0;
			2'b01: b_count = 3'h1;
			2'b10: b_count = 3'h2;
			2'b11: b_count = 3'h3;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int i = 0; i < lpcb_pkg::NUM_CH; i++) begin
				led_sink_level[i] <= 4'h0;
				led_sink_on[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < lpcb_pkg::NUM_CH; i++) begin
				if (3'(i) >= 3'(lpcb_pkg::NUM_CH) - b_count) begin
					led_sink_level[i] <= lvl_b;
					led_sink_on[i] <= on_b;
				end else begin
					led_sink_level[i] <= lvl_a;
					led_sink_on[i] <= on_a;
				end
			end
		end
	end

	assign chip_enable = (state_ff == lpcb_pkg::LPCB_ST_SOFT) || (state_ff == lpcb_pkg::LPCB_ST_RUN);
	assign startup_active = (state_ff == lpcb_pkg::LPCB_ST_SOFT);
endmodule // lpcb_top
`default_nettype wire

// ===== test/lpcb_host.sv
// host model driving the two enable pulse lines
`timescale 1ns/1ps
`default_nettype none
module lpcb_host (
	// clock
	input wire logic clock,
	// enable lines
	output logic group_a_enable_in,
	output logic group_b_enable_in
);
	localparam int WIDTH = 80; // 3.2 us, above the minimum
	initial begin
		group_a_enable_in = 1'b0;
		group_b_enable_in = 1'b0;
	end
	task automatic set_line(input logic b, input logic v);
		@(posedge clock);
		if (b) group_b_enable_in <= v;
		else group_a_enable_in <= v;
		repeat (WIDTH - 1) @(posedge clock);
	endtask
	// each pulse ends high so the step is kept
	task automatic pulses(input logic b, input int n);
		repeat (n) begin
			set_line(b, 1'b0);
			set_line(b, 1'b1);
		end
	endtask
endmodule // lpcb_host
`default_nettype wire

// ===== test/lpcb_monitor.sv
// port checker for the led pulse-count brightness top
`timescale 1ns/1ps
`default_nettype none
module lpcb_monitor #(
	parameter int POR_CYCLES = 8,
	parameter int SOFT_START_CYCLES = 20,
	parameter int HOLD_CYCLES = 30
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// pins and outputs
	input wire logic group_a_enable_in,
	input wire logic group_b_enable_in,
	input wire logic [lpcb_pkg::STEP_W-1:0] led_sink_level [lpcb_pkg::NUM_CH],
	input wire logic [lpcb_pkg::NUM_CH-1:0] led_sink_on,
	input wire logic chip_enable,
	input wire logic startup_active
);
	int por_ff;
	int low_ff;
	int soft_ff;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// por_ff saturates so a long run cannot wrap it; low_ff and soft_ff do not saturate
	always_ff @(posedge clock) begin
		por_ff <= !rstn ? 0 : (por_ff < 65535 ? por_ff + 1 : por_ff);
	end
	always_ff @(posedge clock) begin
		low_ff <= (!rstn || group_a_enable_in || group_b_enable_in) ? 0 : low_ff + 1;
	end
	always_ff @(posedge clock) begin
		soft_ff <= (!rstn || !startup_active) ? 0 : soft_ff + 1;
	end
	a_soft_dark: assert property (startup_active |-> led_sink_on == '0)
		else $error("drive on during soft-start");
	a_soft_enabled: assert property (startup_active |-> chip_enable)
		else $error("soft-start without internal enable");
	a_standby_dark: assert property (!chip_enable |-> led_sink_on == '0)
		else $error("drive on in standby");
	a_zero_off: assert property (led_sink_on[0] |-> led_sink_level[0] != 4'h0)
		else $error("drive on at zero level");
	a_group_a_fixed: assert property (led_sink_level[0] == led_sink_level[2])
		else $error("first three channels differ");
	a_low_dark: assert property (!group_a_enable_in [*8] |-> !led_sink_on[0])
		else $error("channel on while its enable low");
	a_por_gate: assert property (por_ff < POR_CYCLES |-> !chip_enable)
		else $error("woke during power-on reset");
	a_soft_length: assert property ($fell(startup_active) && chip_enable |->
		soft_ff >= SOFT_START_CYCLES - 1 && soft_ff <= SOFT_START_CYCLES + 1)
		else $error("soft-start length wrong");
	a_hold_drop: assert property ($fell(chip_enable) |-> low_ff >= HOLD_CYCLES)
		else $error("standby entered too early");
endmodule // lpcb_monitor
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the led pulse-count brightness top
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock, rstn, sel_hi, sel_lo, en_a, en_b, chip_en, start;
	logic [lpcb_pkg::STEP_W-1:0] lvl [lpcb_pkg::NUM_CH];
	logic [lpcb_pkg::NUM_CH-1:0] on;
	logic [3:0] exp;
	int bad_count = 0;
	int checks = 0;
	lpcb_host lpcb_host_i (.clock(clock), .group_a_enable_in(en_a), .group_b_enable_in(en_b));
	lpcb_top #(.POR_CYCLES(300), .SOFT_START_CYCLES(600), .HOLD_CYCLES(200)) lpcb_top_i (
		.clock(clock), .rstn(rstn), .group_a_enable_in(en_a), .group_b_enable_in(en_b),
		.group_split_sel_hi(sel_hi), .group_split_sel_lo(sel_lo), .led_sink_level(lvl),
		.led_sink_on(on), .chip_enable(chip_en), .startup_active(start));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic chk(input logic ok, input string m);
		checks++;
		if (!ok) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wait_run();
		for (int i = 0; i < 800 && start !== 1'b0; i++) @(posedge clock);
		repeat (3) @(posedge clock);
		chk(start === 1'b0 && chip_en === 1'b1, "soft-start did not end");
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_por();
		lpcb_host_i.pulses(1'b0, 1);
		lpcb_host_i.set_line(1'b0, 1'b0);
		chk(chip_en === 1'b0, "pulse in power-on reset woke device");
		repeat (250) @(posedge clock);
		chk(chip_en === 1'b0, "ignored pulse left a wake");
		$display("t_por done");
	endtask
	task automatic t_start();
		lpcb_host_i.set_line(1'b0, 1'b1);
		chk(start === 1'b1 && on === 6'h00, "no dark soft-start on rise");
		lpcb_host_i.pulses(1'b0, 2);
		wait_run();
		chk(lvl[0] === 4'hD && on === 6'h07, "pulses in soft-start lost");
		$display("t_start done");
	endtask
	task automatic t_steps();
		for (int s = 4; s <= 17; s++) begin
			lpcb_host_i.pulses(1'b0, 1);
			exp = (s == 17) ? 4'hF : 4'(16 - s);
			chk(lvl[0] === exp && on[0] === (exp != 4'h0), "step level wrong");
		end
		chk(lvl[0] === 4'hF, "no wrap to full");
		$display("t_steps done");
	endtask
	task automatic t_split();
		logic [5:0] mask [4] = '{6'h00, 6'h20, 6'h30, 6'h38};
		lpcb_host_i.set_line(1'b1, 1'b1);
		for (int c = 0; c < 4; c++) begin
			@(posedge clock);
			{sel_hi, sel_lo} <= 2'(c);
			repeat (5) @(posedge clock);
			lpcb_host_i.set_line(1'b0, 1'b0);
			chk(on === mask[c], "channel split wrong");
			lpcb_host_i.set_line(1'b0, 1'b1);
		end
		chk(lvl[0] === 4'hB && lvl[5] === 4'hF, "groups not independent");
		$display("t_split done");
	endtask
	task automatic t_hold();
		lpcb_host_i.set_line(1'b0, 1'b0);
		lpcb_host_i.set_line(1'b1, 1'b0);
		repeat (60) @(posedge clock);
		chk(chip_en === 1'b1, "standby before hold time");
		repeat (80) @(posedge clock);
		chk(chip_en === 1'b0 && on === 6'h00, "no standby after hold");
		lpcb_host_i.set_line(1'b0, 1'b1);
		wait_run();
		chk(lvl[0] === 4'hF && on[0] === 1'b1, "counter not cleared");
		$display("t_hold done");
	endtask
	initial begin
		rstn = 1'b0;
		sel_hi = 1'b1;
		sel_lo = 1'b1;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		t_por();
		t_start();
		t_steps();
		t_split();
		t_hold();
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		stop_test();
	end
endmodule // tb
bind lpcb_top lpcb_monitor #(.POR_CYCLES(POR_CYCLES), .SOFT_START_CYCLES(SOFT_START_CYCLES),
	.HOLD_CYCLES(HOLD_CYCLES)) lpcb_monitor_i (.clock(clock), .rstn(rstn),
	.group_a_enable_in(group_a_enable_in), .group_b_enable_in(group_b_enable_in),
	.led_sink_level(led_sink_level), .led_sink_on(led_sink_on),
	.chip_enable(chip_enable), .startup_active(startup_active));
`default_nettype wire
